// ==== hw/coil_driver_pkg.sv ====
/*
 * constants and carrier types for the coil driver register bank.
 * assumes a 25 MHz system clock and a two-wire serial host.
 */
package coil_driver_pkg;
    // register offsets
    localparam logic [7:0] ADDR_MAKER_PART = 8'h00;
    localparam logic [7:0] ADDR_REVISION = 8'h01;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_CURRENT_HIGH = 8'h03;
    localparam logic [7:0] ADDR_CURRENT_LOW = 8'h04;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h05;
    localparam logic [7:0] ADDR_DRIVE_MODE = 8'h06;
    localparam logic [7:0] ADDR_SHAPER_CUTOFF = 8'h07;
    localparam logic [7:0] ADDR_EDGE_RATE_LOOP = 8'h08;
    // field positions
    localparam int SOFT_CLEAR_BIT = 0;
    localparam int SHAPER_EN_BIT = 1;
    localparam int TRIP_BIT = 0;
    localparam int OPEN_BIT = 2;
    localparam int SHORT_BIT = 3;
    localparam int HEAT_BIT = 4;
    localparam int SELF_CHECK_BIT = 5;
    // writable bit masks; everything else reads zero
    localparam logic [7:0] MASK_CONTROL = 8'h03;
    localparam logic [7:0] MASK_CURRENT_HIGH = 8'h03;
    localparam logic [7:0] MASK_MODE = 8'hde;
    localparam logic [7:0] MASK_EDGE_RATE = 8'h3f;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // timing
    localparam int CLOCK_HZ = 25000000;
    localparam int SETTLE_US = 1000;
    localparam int RETRY_MS = 100;
    localparam int SETTLE_CYCLES = CLOCK_HZ / 1000000 * SETTLE_US;
    localparam int RETRY_CYCLES = CLOCK_HZ / 1000 * RETRY_MS;

    // analog fault detector levels
    typedef struct packed {
        logic bridged;
        logic load_missing;
        logic overcurrent;
        logic overheat;
    } fault_in_s;

    // configuration handed to the analog and shaper side
    typedef struct packed {
        logic ringing_shaper_enable;
        logic [1:0] shaper_octave;
        logic [5:0] shaper_divisor;
        logic auto_restart;
        logic spread_spectrum;
        logic [2:0] switching_rate_select;
        logic linear_output;
        logic [1:0] loop_zero_select;
        logic edge_rate_limit_enable;
        logic [2:0] edge_rate_select;
    } drive_cfg_s;
endpackage

// ==== hw/coil_driver_regs_self_check_enable.sv ====
/*
 * register bank, two-wire serial slave, diagnostic and overcurrent logic
 * of the coil driver. assumes scl and sda arrive from pins (synchronised
 * here), an external open-drain buffer, and analog fault detector levels.
 */
`timescale 1ns/1ns
module coil_driver_regs_self_check_enable #(
    parameter logic [6:0] DEVICE_ADDR = 7'h1c, // arbitrary bus address
    parameter logic [3:0] MAKER_CODE = 4'h9, // arbitrary value
    parameter logic [3:0] PART_CODE = 4'h5, // arbitrary value
    parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
    parameter int SETTLE_CYCLES = coil_driver_pkg::SETTLE_CYCLES,
    parameter int RETRY_CYCLES = coil_driver_pkg::RETRY_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire coil_driver_pkg::fault_in_s fault_in,
    output logic [9:0] drive_code_out,
    output logic test_current_active,
    output logic stage_off,
    output logic standby,
    output coil_driver_pkg::drive_cfg_s cfg_out
);
    typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK} link_e;

    // two-flop synchronisers for pins and fault levels
    logic [5:0] meta_reg, sync_reg;
    logic scl_prev_reg, sda_prev_reg;
    always_ff @(posedge clock) begin
        meta_reg <= {scl_in, sda_in, fault_in};
        sync_reg <= meta_reg;
        scl_prev_reg <= sync_reg[5];
        sda_prev_reg <= sync_reg[4];
    end
    wire scl_s = sync_reg[5];
    wire sda_s = sync_reg[4];
    wire bridged_s = sync_reg[3];
    wire missing_s = sync_reg[2];
    wire overcur_s = sync_reg[1];
    wire overheat_s = sync_reg[0];
    wire scl_rise = scl_s & ~scl_prev_reg;
    wire scl_fall = ~scl_s & scl_prev_reg;
    wire start_seen = scl_s & scl_prev_reg & ~sda_s & sda_prev_reg;
    wire stop_seen = scl_s & scl_prev_reg & sda_s & ~sda_prev_reg;

    // serial slave state
    link_e link_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg, ptr_reg, rd_byte_reg, wr_data_reg;
    logic rw_reg, wr_strobe_reg, sda_oe_reg, high_seen_reg;
    logic [7:0] read_word;

    // register storage
    logic [1:0] control_reg, current_high_reg;
    logic [7:0] current_low_reg, mode_reg, shaper_reg;
    logic [5:0] edge_rate_reg;
    logic [9:0] committed_reg;
    logic self_check_reg, bridged_reg, missing_reg, trip_reg, heat_reg;
    logic [21:0] settle_reg, retry_reg;

    wire wr_control = wr_strobe_reg && ptr_reg == coil_driver_pkg::ADDR_SYSTEM_CONTROL;
    wire wr_high = wr_strobe_reg && ptr_reg == coil_driver_pkg::ADDR_CURRENT_HIGH;
    wire wr_low = wr_strobe_reg && ptr_reg == coil_driver_pkg::ADDR_CURRENT_LOW;
    wire wr_status = wr_strobe_reg && ptr_reg == coil_driver_pkg::ADDR_FAULT_STATUS;
    wire wr_mode = wr_strobe_reg && ptr_reg == coil_driver_pkg::ADDR_DRIVE_MODE;
    wire wr_shaper = wr_strobe_reg && ptr_reg == coil_driver_pkg::ADDR_SHAPER_CUTOFF;
    wire wr_edge = wr_strobe_reg && ptr_reg == coil_driver_pkg::ADDR_EDGE_RATE_LOOP;
    wire soft_clear_now = wr_control && wr_data_reg[coil_driver_pkg::SOFT_CLEAR_BIT];
    wire commit_now = wr_low && high_seen_reg;
    wire in_standby = committed_reg == 10'h000;
    wire settled = settle_reg == 22'(SETTLE_CYCLES);
    wire retry_due = retry_reg == 22'(RETRY_CYCLES);

    // read view; don't-care and reserved bits return zero
    always_comb begin
        case (ptr_reg)
            coil_driver_pkg::ADDR_MAKER_PART: read_word = {MAKER_CODE, PART_CODE};
            coil_driver_pkg::ADDR_REVISION: read_word = {4'h0, REVISION_CODE};
            coil_driver_pkg::ADDR_SYSTEM_CONTROL: read_word = {6'h00, control_reg};
            coil_driver_pkg::ADDR_CURRENT_HIGH: read_word = {6'h00, current_high_reg};
            coil_driver_pkg::ADDR_CURRENT_LOW: read_word = current_low_reg;
            coil_driver_pkg::ADDR_FAULT_STATUS:
                read_word = {2'h0, self_check_reg, heat_reg, bridged_reg, missing_reg, 1'b0, trip_reg};
            coil_driver_pkg::ADDR_DRIVE_MODE: read_word = mode_reg;
            coil_driver_pkg::ADDR_SHAPER_CUTOFF: read_word = shaper_reg;
            coil_driver_pkg::ADDR_EDGE_RATE_LOOP: read_word = {2'h0, edge_rate_reg};
            default: read_word = 8'h00;
        endcase
    end

    // serial slave: sample at scl rise, drive sda after scl fall
    always_ff @(posedge clock) begin
        wr_strobe_reg <= 1'b0;
        if (sys_rst) begin
            link_reg <= S_IDLE;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rd_byte_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            rw_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            high_seen_reg <= 1'b0;
        end else if (start_seen) begin
            link_reg <= S_ADDR;
            bit_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            high_seen_reg <= 1'b0;
        end else if (stop_seen) begin
            link_reg <= S_IDLE;
            sda_oe_reg <= 1'b0;
            high_seen_reg <= 1'b0;
        end else begin
            if (wr_high) begin
                high_seen_reg <= 1'b1;
            end
            case (link_reg)
                S_ADDR, S_PTR, S_WR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == 4'h8) begin
                        sda_oe_reg <= 1'b1;
                        if (link_reg == S_ADDR) begin
                            rw_reg <= shift_reg[0];
                            link_reg <= S_ADDR_ACK;
                            if (shift_reg[7:1] != DEVICE_ADDR) begin
                                sda_oe_reg <= 1'b0;
                                link_reg <= S_IDLE;
                            end
                        end else if (link_reg == S_PTR) begin
                            ptr_reg <= shift_reg;
                            link_reg <= S_PTR_ACK;
                        end else begin
                            wr_data_reg <= shift_reg;
                            wr_strobe_reg <= 1'b1;
                            link_reg <= S_WR_ACK;
                        end
                    end
                end
                S_ADDR_ACK, S_PTR_ACK, S_WR_ACK: begin
                    if (scl_fall) begin
                        bit_reg <= 4'h0;
                        sda_oe_reg <= 1'b0;
                        if (link_reg == S_WR_ACK) begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        link_reg <= (link_reg == S_ADDR_ACK) ? S_PTR : S_WR;
                        if (link_reg == S_ADDR_ACK && rw_reg) begin
                            rd_byte_reg <= read_word;
                            sda_oe_reg <= ~read_word[7];
                            link_reg <= S_RD;
                        end
                    end
                end
                S_RD: begin
                    if (scl_rise) begin
                        bit_reg <= bit_reg + 4'h1;
                        rd_byte_reg <= {rd_byte_reg[6:0], 1'b0};
                    end else if (scl_fall) begin
                        sda_oe_reg <= (bit_reg == 4'h8) ? 1'b0 : ~rd_byte_reg[7];
                        if (bit_reg == 4'h8) begin
                            link_reg <= S_RD_ACK;
                        end
                    end
                end
                S_RD_ACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            link_reg <= S_IDLE; // host nack ends the read
                        end else begin
                            ptr_reg <= ptr_reg + 8'h01;
                            bit_reg <= 4'h0;
                        end
                    end else if (scl_fall) begin
                        rd_byte_reg <= read_word;
                        sda_oe_reg <= ~read_word[7];
                        link_reg <= S_RD;
                    end
                end
                default: link_reg <= S_IDLE;
            endcase
        end
    end

    // register writes; soft clear returns all but its own bit to zero
    always_ff @(posedge clock) begin
        if (sys_rst || soft_clear_now) begin
            control_reg <= {1'b0, !sys_rst};
            current_high_reg <= 2'h0;
            current_low_reg <= coil_driver_pkg::RESET_VALUE;
            committed_reg <= 10'h000;
            self_check_reg <= 1'b0;
            mode_reg <= coil_driver_pkg::RESET_VALUE;
            shaper_reg <= coil_driver_pkg::RESET_VALUE;
            edge_rate_reg <= 6'h00;
        end else begin
            if (wr_control) begin
                control_reg <= wr_data_reg[1:0] & coil_driver_pkg::MASK_CONTROL[1:0];
            end
            if (wr_high) begin
                current_high_reg <= wr_data_reg[1:0];
            end
            if (wr_low) begin
                current_low_reg <= wr_data_reg;
            end
            if (commit_now) begin
                committed_reg <= {current_high_reg, wr_data_reg};
            end
            if (wr_status) begin
                self_check_reg <= wr_data_reg[coil_driver_pkg::SELF_CHECK_BIT];
            end
            if (wr_mode) begin
                mode_reg <= wr_data_reg & coil_driver_pkg::MASK_MODE;
            end
            if (wr_shaper) begin
                shaper_reg <= wr_data_reg;
            end
            if (wr_edge) begin
                edge_rate_reg <= wr_data_reg[5:0];
            end
        end
    end

    // diagnostic settle timer and fault flags
    always_ff @(posedge clock) begin
        if (sys_rst || !self_check_reg) begin
            settle_reg <= 22'h000000;
        end else if (!settled) begin
            settle_reg <= settle_reg + 22'h000001;
        end
        bridged_reg <= !sys_rst && self_check_reg && settled && bridged_s;
        missing_reg <= !sys_rst && self_check_reg && settled && missing_s;
        heat_reg <= !sys_rst && overheat_s;
    end

    // overcurrent trip with optional timed retry; standby releases it
    always_ff @(posedge clock) begin
        if (sys_rst || !trip_reg || retry_due) begin
            retry_reg <= 22'h000000;
        end else if (mode_reg[7]) begin
            retry_reg <= retry_reg + 22'h000001;
        end
        if (sys_rst || soft_clear_now) begin
            trip_reg <= 1'b0;
        end else if (overcur_s && !in_standby) begin
            trip_reg <= 1'b1;
        end else if (in_standby || (retry_due && mode_reg[7])) begin
            trip_reg <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            drive_code_out <= 10'h000;
            test_current_active <= 1'b0;
            stage_off <= 1'b0;
            standby <= 1'b1;
            cfg_out <= '0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= sda_oe_reg;
            drive_code_out <= self_check_reg ? 10'h000 : committed_reg;
            test_current_active <= self_check_reg;
            stage_off <= trip_reg || heat_reg;
            standby <= in_standby && !self_check_reg;
            cfg_out <= {control_reg[coil_driver_pkg::SHAPER_EN_BIT], shaper_reg, mode_reg[7:6],
                        mode_reg[4:1], edge_rate_reg};
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    flags_idle_zero_a: assert property (!self_check_reg |=> !bridged_reg && !missing_reg)
        else $error("fault flag set without self-check");
    flags_settle_a: assert property ($rose(self_check_reg) |=> !bridged_reg [*8])
        else $error("fault flag before settle time");
    test_current_a: assert property (self_check_reg |=> test_current_active && drive_code_out == 10'h000)
        else $error("test current not applied");
    high_only_a: assert property (wr_high |=> $stable(committed_reg))
        else $error("code changed by high byte alone");
    commit_code_a: assert property (commit_now && !soft_clear_now |=>
        committed_reg == {$past(current_high_reg), $past(wr_data_reg)})
        else $error("code not committed");
    trip_set_a: assert property (overcur_s && !in_standby && !soft_clear_now |=> trip_reg)
        else $error("overcurrent not latched");
    soft_clear_a: assert property (soft_clear_now |=> mode_reg == 8'h00 && control_reg == 2'h1 && in_standby)
        else $error("soft clear incomplete");
    shaper_follow_a: assert property (wr_control && !soft_clear_now ##1 1 |=>
        cfg_out.ringing_shaper_enable == $past(wr_data_reg[1], 2))
        else $error("shaper enable not applied");
endmodule // coil_driver_regs_self_check_enable

// ==== dv/i2c_host_model.sv ====
/* two-wire host model that drives the coil driver serial port.
   assumes the bench resolves the open-drain data wire with a pull-up. */
`timescale 1ns/1ns
module i2c_host_model (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    // bus idles released, clock high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // host lines move only at falling system clock edges
    task automatic gap(input int n);
        repeat (n) @(negedge clock);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        gap(4);
        sda_low = 1'b0;
        gap(4);
        scl = 1'b1;
        gap(8);
        sda_low = 1'b1;
        gap(8);
        scl = 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        gap(4);
        sda_low = 1'b1;
        gap(4);
        scl = 1'b1;
        gap(8);
        sda_low = 1'b0;
        gap(8);
    endtask
    // one bit: data set mid low phase, wire sampled late in high phase
    task automatic xfer(input logic b, output logic s);
        gap(4);
        sda_low = ~b;
        gap(4);
        scl = 1'b1;
        gap(6);
        s = sda_line;
        gap(2);
        scl = 1'b0;
    endtask
    // byte out msb first; ack is high when the device pulled the ninth bit low
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(d[i], s);
        xfer(1'b1, s);
        ack = ~s;
    endtask
    // byte in; more selects ack or nack
    task automatic get(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(~more, s);
    endtask
endmodule // i2c_host_model

// ==== dv/coil_driver_regs_self_check_enable_bench.sv ====
/* self-checking bench for the coil driver register bank and diagnostics.
   assumes the host model above and default identity parameters. */
`timescale 1ns/1ns
module coil_driver_regs_self_check_enable_bench;
    localparam int SETTLE = 1500;
    localparam int RETRY = 50;
    typedef struct packed {logic [7:0] ptr; logic [7:0] wr; logic [7:0] rd;} row_s;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic scl, sda_low, sda_out, sda_oe, test_current_active, stage_off, standby, ack;
    logic [7:0] rd;
    logic [9:0] drive_code_out;
    coil_driver_pkg::fault_in_s fault_in = '0;
    coil_driver_pkg::drive_cfg_s cfg_out;
    int err_total = 0;
    int num_checks = 0;
    wire sda_line = ~(sda_low | (sda_oe & ~sda_out));
    // pointer, written byte, expected read-back
    row_s rows [8] = '{'{8'h00, 8'hff, 8'h95}, '{8'h01, 8'hff, 8'h03}, '{8'h02, 8'hfe, 8'h02},
        '{8'h03, 8'hfd, 8'h01}, '{8'h04, 8'h5a, 8'h5a}, '{8'h06, 8'hff, 8'hde},
        '{8'h07, 8'ha5, 8'ha5}, '{8'h08, 8'h3f, 8'h3f}};
    always #20 clock = ~clock;
    i2c_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    coil_driver_regs_self_check_enable #(.DEVICE_ADDR(7'h1c), .MAKER_CODE(4'h9), .PART_CODE(4'h5), .REVISION_CODE(4'h3),
        .SETTLE_CYCLES(SETTLE), .RETRY_CYCLES(RETRY)) dut (
        .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .fault_in(fault_in), .drive_code_out(drive_code_out),
        .test_current_active(test_current_active), .stage_off(stage_off), .standby(standby), .cfg_out(cfg_out));
    // compares and counts
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // one register in its own transaction
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host.start();
        host.put(8'h38, ack);
        check("addr ack", ack, 1);
        host.put(p, ack);
        host.put(d, ack);
        host.stop();
    endtask
    // coil code as high then low in one transaction
    task automatic wr_code(input logic [9:0] c);
        host.start();
        host.put(8'h38, ack);
        host.put(8'h03, ack);
        host.put({6'h00, c[9:8]}, ack);
        host.put(c[7:0], ack);
        host.stop();
    endtask
    task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
        host.start();
        host.put(8'h38, ack);
        host.put(p, ack);
        host.start();
        host.put(8'h39, ack);
        host.get(1'b0, d);
        host.stop();
    endtask
    // main sequence
    initial begin
        settle(20);
        sys_rst = 1'b0;
        settle(4);
        check("standby", standby, 1);
        check("code", drive_code_out, 0);
        for (int p = 2; p <= 8; p++) begin
            rd_reg(8'(p), rd);
            check("reset reg", rd, 0);
        end
        foreach (rows[i]) begin
            wr(rows[i].ptr, rows[i].wr);
            rd_reg(rows[i].ptr, rd);
            check("row", rd, rows[i].rd);
        end
        check("shaper", cfg_out.ringing_shaper_enable, 1);
        check("cfg", cfg_out, {1'b1, 2'h2, 6'h25, 1'b1, 1'b1, 3'h7, 1'b1, 2'h3, 1'b1, 3'h7});
        check("code alone", drive_code_out, 0);
        host.start();
        host.put(8'h3a, ack);
        host.stop();
        check("foreign ack", ack, 0);
        wr_code(10'h210);
        check("code", drive_code_out, 10'h210);
        check("standby", standby, 0);
        // self-check with a bridged coil
        fault_in.bridged = 1'b1;
        wr(8'h05, 8'hff);
        check("test current", test_current_active, 1);
        check("code forced", drive_code_out, 0);
        rd_reg(8'h05, rd);
        check("early flags", rd, 8'h20);
        settle(SETTLE);
        fault_in.load_missing = 1'b1;
        settle(10);
        rd_reg(8'h05, rd);
        check("flags", rd, 8'h2c);
        wr(8'h05, 8'h00);
        rd_reg(8'h05, rd);
        check("flags off", rd, 8'h00);
        check("code back", drive_code_out, 10'h210);
        fault_in = '0;
        // overcurrent with auto-restart enabled, then disabled
        fault_in.overcurrent = 1'b1;
        settle(10);
        check("trip", stage_off, 1);
        rd_reg(8'h05, rd);
        check("trip flag", rd, 8'h01);
        fault_in.overcurrent = 1'b0;
        settle(2 * RETRY + 10);
        check("retry", stage_off, 0);
        wr(8'h06, 8'h00);
        fault_in.overcurrent = 1'b1;
        settle(10);
        fault_in.overcurrent = 1'b0;
        settle(3 * RETRY);
        check("latched", stage_off, 1);
        wr_code(10'h000);
        check("standby", standby, 1);
        check("unlatched", stage_off, 0);
        // soft clear
        wr_code(10'h155);
        wr(8'h02, 8'h03);
        check("standby", standby, 1);
        check("shaper", cfg_out.ringing_shaper_enable, 0);
        rd_reg(8'h07, rd);
        check("cleared", rd, 8'h00);
        rd_reg(8'h02, rd);
        check("clear bit", rd, 8'h01);
        // second reset mid-run
        wr(8'h07, 8'h5a);
        sys_rst = 1'b1;
        settle(3);
        sys_rst = 1'b0;
        settle(4);
        rd_reg(8'h07, rd);
        check("rereset", rd, 8'h00);
        tally_and_finish();
    end
    // watchdog
    initial begin
        settle(90000);
        err_total++;
        tally_and_finish();
    end
endmodule // coil_driver_regs_self_check_enable_bench
